// ===== vsl_line_state.sv
`timescale 1ns/100ps
// Contract
// - dead needs all voltages and currents low
// - live needs all three voltages high
// - per-phase voltage present outputs
// - per-phase current present outputs
// - inhibit input disables line-state function
// - block emits no event records
// - residual mode: residual voltage high, current low
// - negative mode: neg voltage high, current low
// - special mode: residual voltage, both currents low
// - arm after 200 ms continuous live line
// - disarm on dead line, unless an old failure latches
// - fail after condition holds 4 ms
// - supervision needs enable on, inhibit off
// - clear failure 200 ms after condition gone
// - dead after 100 ms failure: latch it
// - dead before 100 ms failure: clear it
// - enable setting defaults off, outputs off
// - voltage threshold 10 to 100 %, default 60
// - current threshold 2 to 100 %, default 10
module vsl_line_state
    import vsl_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // settings
    input  wire vsl_setting_type setting,
    // measurements
    input  wire vsl_meas_type    meas,
    // user control
    input  wire logic            line_state_inhibit,
    // per-phase starts
    output logic [2:0]           phase_voltage_present,
    output logic [2:0]           phase_current_present,
    // line state
    output logic                 line_dead_flag,
    output logic                 line_live_flag,
    // supervision result
    output logic                 vt_fail_flag
);

    // ============================================================
    // enable and thresholds
    // ============================================================

    logic                           active;
    logic [N_CMP-1:0][15:0]         cmp_mag;
    logic [N_CMP-1:0][15:0]         cmp_level;
    logic [N_CMP-1:0]               cmp_above;

    // the whole function runs only when enabled and not inhibited
    assign active = setting.enable & ~line_state_inhibit;

    // route magnitudes and clamped levels to the comparator slots
    always_comb
    begin
        for (int k = 0; k < 3; k++)
        begin
            cmp_mag[CMP_V0 + k]   = meas.phase_volt[k];
            cmp_mag[CMP_I0 + k]   = meas.phase_curr[k];
            cmp_level[CMP_V0 + k] = pct_to_level(setting.volt_pct, VOLT_PCT_MIN);
            cmp_level[CMP_I0 + k] = pct_to_level(setting.curr_pct, CURR_PCT_MIN);
        end
        cmp_mag[CMP_RESV]   = meas.residual_voltage;
        cmp_mag[CMP_RESI]   = meas.residual_current;
        cmp_mag[CMP_NEGV]   = meas.neg_seq_voltage;
        cmp_mag[CMP_NEGI]   = meas.neg_seq_current;
        cmp_level[CMP_RESV] = pct_to_level(setting.res_volt_pct, 7'h01);
        cmp_level[CMP_RESI] = pct_to_level(setting.res_curr_pct, 7'h01);
        cmp_level[CMP_NEGV] = pct_to_level(setting.neg_volt_pct, 7'h01);
        cmp_level[CMP_NEGI] = pct_to_level(setting.neg_curr_pct, 7'h01);
    end

    // ============================================================
    // comparators
    // ============================================================

    // one hysteresis comparator per magnitude
    for (genvar g = 0; g < N_CMP; g++)
    begin : g_cmp
        vsl_hyst_cmp u_cmp
        (
            .clk     (clk),
            .sys_rst (sys_rst),
            .clear   (~active),
            .mag     (cmp_mag[g]),
            .level   (cmp_level[g]),
            .above   (cmp_above[g])
        );
    end

    // per-phase starts come straight from comparator flops
    assign phase_voltage_present = cmp_above[CMP_V0 +: 3];
    assign phase_current_present = cmp_above[CMP_I0 +: 3];

    // ============================================================
    // line state
    // ============================================================

    logic dead_r;
    logic live_r;

    // dead and live decisions; no event output exists here
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dead_r <= 1'b0;
            live_r <= 1'b0;
        end
        else if (!active)
        begin
            dead_r <= 1'b0;
            live_r <= 1'b0;
        end
        else
        begin
            dead_r <= ~(|cmp_above[CMP_V0 +: 3]) & ~(|cmp_above[CMP_I0 +: 3]);
            live_r <= &cmp_above[CMP_V0 +: 3];
        end
    end

    assign line_dead_flag = dead_r;
    assign line_live_flag = live_r;

    // ============================================================
    // failure condition
    // ============================================================

    logic fail_cond;

    // select the condition of the chosen mode
    always_comb
    begin
        unique case (setting.mode)
            MODE_RESIDUAL:
                fail_cond = cmp_above[CMP_RESV] & ~cmp_above[CMP_RESI];
            MODE_NEG_SEQ:
                fail_cond = cmp_above[CMP_NEGV] & ~cmp_above[CMP_NEGI];
            MODE_SPECIAL:
                fail_cond = cmp_above[CMP_RESV] & ~cmp_above[CMP_RESI]
                            & ~cmp_above[CMP_NEGI];
            default:
                fail_cond = 1'b0;
        endcase
    end

    // ============================================================
    // millisecond tick
    // ============================================================

    localparam int unsigned DIV_W = $clog2(TICK_LEN + 1);

    logic [DIV_W-1:0] div_r;
    logic             tick_r;

    // divider yields a one-cycle enable every millisecond
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end
        else if (div_r == DIV_W'(TICK_LEN - 1))
        begin
            div_r  <= '0;
            tick_r <= 1'b1;
        end
        else
        begin
            div_r  <= div_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // ============================================================
    // timers (counted in ticks, one extra so the time is a minimum)
    // ============================================================

    vsl_state_type    state_r;
    vsl_state_type    state_nxt;
    logic [TMR_W-1:0] live_cnt_r;
    logic [TMR_W-1:0] qual_cnt_r;
    logic [TMR_W-1:0] clr_cnt_r;
    logic [TMR_W-1:0] on_cnt_r;
    logic             armed_ok;
    logic             qual_ok;
    logic             clr_ok;
    logic             old_fail;

    // saturating tick counter step
    function automatic logic [TMR_W-1:0] tmr_step(logic [TMR_W-1:0] c, logic t);
        if (t && c != '1)
        begin
            return c + 1'b1;
        end
        return c;
    endfunction : tmr_step

    assign armed_ok = live_cnt_r > TMR_W'(ARM_MS);
    assign qual_ok  = qual_cnt_r > TMR_W'(QUAL_MS);
    assign clr_ok   = clr_cnt_r  > TMR_W'(CLEAR_MS);
    assign old_fail = on_cnt_r   > TMR_W'(LATCH_MS);

    // live-line duration for arming
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            live_cnt_r <= '0;
        end
        else if (!active || !live_r)
        begin
            live_cnt_r <= '0;
        end
        else
        begin
            live_cnt_r <= tmr_step(live_cnt_r, tick_r);
        end
    end

    // condition qualification while armed
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            qual_cnt_r <= '0;
        end
        else if (state_r != ST_ARMED || !fail_cond)
        begin
            qual_cnt_r <= '0;
        end
        else
        begin
            qual_cnt_r <= tmr_step(qual_cnt_r, tick_r);
        end
    end

    // reset delay once condition disappears on a live line
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clr_cnt_r <= '0;
        end
        else if (state_r != ST_FAILED || fail_cond || !live_r)
        begin
            clr_cnt_r <= '0;
        end
        else
        begin
            clr_cnt_r <= tmr_step(clr_cnt_r, tick_r);
        end
    end

    // age of the failure output, kept while latched
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            on_cnt_r <= '0;
        end
        else if (state_r == ST_FAILED || state_r == ST_LATCHED)
        begin
            on_cnt_r <= tmr_step(on_cnt_r, tick_r);
        end
        else
        begin
            on_cnt_r <= '0;
        end
    end

    // ============================================================
    // supervision state machine
    // ============================================================

    // next state of the supervision
    always_comb
    begin
        state_nxt = state_r;
        if (!active)
        begin
            state_nxt = ST_DISARMED;
        end
        else
        begin
            unique case (state_r)
                ST_DISARMED:
                    if (armed_ok && !dead_r)
                    begin
                        state_nxt = ST_ARMED;
                    end
                ST_ARMED:
                    if (dead_r)
                    begin
                        state_nxt = ST_DISARMED;
                    end
                    else if (qual_ok)
                    begin
                        state_nxt = ST_FAILED;
                    end
                ST_FAILED:
                    if (dead_r && old_fail)
                    begin
                        state_nxt = ST_LATCHED;
                    end
                    else if (dead_r)
                    begin
                        state_nxt = ST_DISARMED;
                    end
                    else if (clr_ok)
                    begin
                        state_nxt = ST_ARMED;
                    end
                ST_LATCHED:
                    if (live_r)
                    begin
                        state_nxt = ST_FAILED;
                    end
            endcase
        end
    end

    // state and failure output registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r      <= ST_DISARMED;
            vt_fail_flag <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            vt_fail_flag <= (state_nxt == ST_FAILED) || (state_nxt == ST_LATCHED);
        end
    end

endmodule : vsl_line_state

// ===== vsl_pkg.sv
// ============================================================
// shared constants and types
// ============================================================
package vsl_pkg;

    // clock and time base
    localparam int unsigned CLK_PERIOD_NS = 20;        // 50 mhz
    localparam int unsigned TICK_NS       = 1_000_000; // one millisecond tick
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    // delays in milliseconds
    localparam int unsigned ARM_MS   = 200; // live line before arming
    localparam int unsigned QUAL_MS  = 4;   // failure condition qualification
    localparam int unsigned CLEAR_MS = 200; // reset delay on a live line
    localparam int unsigned LATCH_MS = 100; // failure age that survives dead line

    // timer width in bits
    localparam int unsigned TMR_W = 8;

    // magnitude scale: a magnitude of LEVEL_PER_PCT * 100 is nominal
    localparam int unsigned MAG_W         = 16;
    localparam int unsigned PCT_W         = 7;
    localparam logic [15:0] LEVEL_PER_PCT = 16'h0064;

    // hysteresis: drop out below DROP_NUM / DROP_DEN of the threshold
    localparam logic [4:0] DROP_NUM = 5'h13;
    localparam logic [4:0] DROP_DEN = 5'h14;

    // comparator slots
    localparam int unsigned N_CMP    = 10;
    localparam int unsigned CMP_V0   = 0;
    localparam int unsigned CMP_I0   = 3;
    localparam int unsigned CMP_RESV = 6;
    localparam int unsigned CMP_RESI = 7;
    localparam int unsigned CMP_NEGV = 8;
    localparam int unsigned CMP_NEGI = 9;

    // setting defaults
    localparam logic       DEF_ENABLE   = 1'b0;
    localparam logic [6:0] DEF_VOLT_PCT = 7'h3c; // 60 %
    localparam logic [6:0] DEF_CURR_PCT = 7'h0a; // 10 %
    localparam logic [6:0] VOLT_PCT_MIN = 7'h0a; // 10 %
    localparam logic [6:0] CURR_PCT_MIN = 7'h02; // 2 %
    localparam logic [6:0] PCT_MAX      = 7'h64; // 100 %

    // supervision modes
    typedef enum logic [1:0]
    {
        MODE_RESIDUAL = 2'b00,
        MODE_NEG_SEQ  = 2'b01,
        MODE_SPECIAL  = 2'b10
    } vsl_mode_type;

    // supervision states
    typedef enum logic [1:0]
    {
        ST_DISARMED = 2'b00,
        ST_ARMED    = 2'b01,
        ST_FAILED   = 2'b10,
        ST_LATCHED  = 2'b11
    } vsl_state_type;

    // settings bundle
    typedef struct packed
    {
        logic         enable;
        logic [6:0]   volt_pct;
        logic [6:0]   curr_pct;
        vsl_mode_type mode;
        logic [6:0]   res_volt_pct;
        logic [6:0]   res_curr_pct;
        logic [6:0]   neg_volt_pct;
        logic [6:0]   neg_curr_pct;
    } vsl_setting_type;

    // magnitudes from the phasor stage
    typedef struct packed
    {
        logic [2:0][15:0] phase_volt;
        logic [2:0][15:0] phase_curr;
        logic [15:0]      residual_voltage;
        logic [15:0]      residual_current;
        logic [15:0]      neg_seq_voltage;
        logic [15:0]      neg_seq_current;
    } vsl_meas_type;

    // percent setting to magnitude level, clamped to the given range
    function automatic logic [15:0] pct_to_level(logic [6:0] pct, logic [6:0] lo);
        logic [6:0] p;
        p = pct;
        if (p < lo)
        begin
            p = lo;
        end
        if (p > PCT_MAX)
        begin
            p = PCT_MAX;
        end
        return 16'({9'h000, p} * LEVEL_PER_PCT);
    endfunction : pct_to_level

endpackage : vsl_pkg

// ===== vsl_hyst_cmp.sv
`timescale 1ns/100ps
// ============================================================
// magnitude comparator with drop-out hysteresis
// ============================================================
module vsl_hyst_cmp
    import vsl_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // control
    input  wire logic        clear,
    // data
    input  wire logic [15:0] mag,
    input  wire logic [15:0] level,
    // result
    output logic             above
);

    logic [20:0] drop_level;
    logic        above_r;

    // drop-out level is the threshold scaled down by the reset ratio
    assign drop_level = 21'(({5'h00, level} * {16'h0000, DROP_NUM}) / {16'h0000, DROP_DEN});

    // pick up above level, drop only below the reduced level
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            above_r <= 1'b0;
        end
        else if (clear)
        begin
            above_r <= 1'b0;
        end
        else if (mag > level)
        begin
            above_r <= 1'b1;
        end
        else if ({5'h00, mag} < drop_level)
        begin
            above_r <= 1'b0;
        end
    end

    assign above = above_r;

endmodule : vsl_hyst_cmp

// ===== vsl_meas_src.sv
`timescale 1ns/100ps
// ========================================
// phasor stage model
// ========================================
module vsl_meas_src
    import vsl_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // commanded magnitudes
    input  wire logic [2:0][15:0] volt,
    input  wire logic [2:0][15:0] curr,
    input  wire logic [3:0][15:0] seq,
    // estimate out
    output vsl_meas_type          meas
);
    // one estimation step of delay, cleared by reset
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meas <= '0;
        end
        else
        begin
            meas <= {volt, curr, seq};
        end
    end
endmodule : vsl_meas_src

// ===== vsl_line_state_chk.sv
`timescale 1ns/100ps
// ========================================
// port checker
// ========================================
module vsl_line_state_chk
    import vsl_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    // clock and reset
    input wire logic            clk,
    input wire logic            sys_rst,
    // inputs
    input wire vsl_setting_type setting,
    input wire vsl_meas_type    meas,
    input wire logic            line_state_inhibit,
    // outputs
    input wire logic [2:0]      phase_voltage_present,
    input wire logic [2:0]      phase_current_present,
    input wire logic            line_dead_flag,
    input wire logic            line_live_flag,
    input wire logic            vt_fail_flag
);
    localparam int YOUNG = (LATCH_MS - 1) * TICK_LEN;
    localparam int OLD   = (LATCH_MS + 2) * TICK_LEN;
    logic on, cond, rv, ri, nv, ni;
    int   c_run_r, n_run_r, f_run_r;

    function automatic logic [15:0] lv(logic [6:0] p);
        return 16'({9'h000, p} * LEVEL_PER_PCT);
    endfunction : lv

    // raw failure condition of the selected mode
    always_comb
    begin
        on = setting.enable && !line_state_inhibit;
        rv = meas.residual_voltage > lv(setting.res_volt_pct);
        ri = meas.residual_current < lv(setting.res_curr_pct);
        nv = meas.neg_seq_voltage > lv(setting.neg_volt_pct);
        ni = meas.neg_seq_current < lv(setting.neg_curr_pct);
        case (setting.mode)
            MODE_RESIDUAL: cond = on && rv && ri;
            MODE_NEG_SEQ:  cond = on && nv && ni;
            MODE_SPECIAL:  cond = on && rv && ri && ni;
            default:       cond = 1'b0;
        endcase
    end

    // run lengths of condition, its absence and the failure flag
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            c_run_r <= 0;
            n_run_r <= 0;
            f_run_r <= 0;
        end
        else
        begin
            c_run_r <= cond ? c_run_r + 1 : 0;
            n_run_r <= cond ? 0 : n_run_r + 1;
            f_run_r <= vt_fail_flag ? f_run_r + 1 : 0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_dead_start;
        $rose(line_dead_flag) && vt_fail_flag;
    endsequence

    a_dead_all_low: assert property (
        line_dead_flag |-> $past(phase_voltage_present == 3'h0 && phase_current_present == 3'h0))
        else $error("dead flag while a start is active");
    a_live_all_volt: assert property (
        line_live_flag |-> $past(phase_voltage_present == 3'h7))
        else $error("live flag without all voltage starts");
    a_volt_pickup: assert property (
        on && setting.volt_pct >= VOLT_PCT_MIN && setting.volt_pct <= PCT_MAX
        && meas.phase_volt[0] > lv(setting.volt_pct) |=> phase_voltage_present[0])
        else $error("voltage start missing above level");
    a_curr_pickup: assert property (
        on && setting.curr_pct >= CURR_PCT_MIN && setting.curr_pct <= PCT_MAX
        && meas.phase_curr[1] > lv(setting.curr_pct) |=> phase_current_present[1])
        else $error("current start missing above level");
    a_off_clears: assert property (
        !on |=> {phase_voltage_present, phase_current_present, line_dead_flag,
        line_live_flag, vt_fail_flag} == 9'h000)
        else $error("outputs active while function is off");
    a_qual_time: assert property (
        $rose(vt_fail_flag) |-> c_run_r >= QUAL_MS * TICK_LEN)
        else $error("failure raised before qualification time");
    a_reset_delay: assert property (
        $fell(vt_fail_flag) && line_live_flag |-> n_run_r >= CLEAR_MS * TICK_LEN)
        else $error("failure cleared too early on live line");
    a_young_clear: assert property (
        s_dead_start ##0 (f_run_r < YOUNG) |-> ##[1:3] !vt_fail_flag)
        else $error("young failure kept over dead line");
    a_old_latch: assert property (
        s_dead_start ##0 (f_run_r > OLD) |=> vt_fail_flag [*8])
        else $error("old failure dropped at dead line");
endmodule : vsl_line_state_chk

bind vsl_line_state vsl_line_state_chk #(.TICK_LEN(TICK_LEN)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .setting(setting), .meas(meas),
    .line_state_inhibit(line_state_inhibit), .phase_voltage_present(phase_voltage_present),
    .phase_current_present(phase_current_present), .line_dead_flag(line_dead_flag),
    .line_live_flag(line_live_flag), .vt_fail_flag(vt_fail_flag));

// ===== vsl_line_state_test.sv
`timescale 1ns/100ps
// ========================================
// self-checking bench
// ========================================
module vsl_line_state_test
    import vsl_pkg::*;
;
    localparam int unsigned TL = 10; // cycles per ms tick
    localparam logic [15:0] VH = 16'h1f40, VL = 16'h03e8, H = 16'h0bb8;
    localparam logic [15:0] L  = 16'h0064, Z = 16'h0000;
    logic             clk, sys_rst, inh, dead, live, fail;
    logic [2:0]       pvp, pcp;
    logic [2:0][15:0] volt, curr, v, c;
    logic [3:0][15:0] seq;
    logic [3:0][15:0] fv [3];
    logic [3:0][15:0] bv [3];
    vsl_setting_type  st;
    vsl_meas_type     meas;
    int               failures, tests_run, cyc;

    vsl_meas_src u_src (.clk(clk), .sys_rst(sys_rst), .volt(volt), .curr(curr),
        .seq(seq), .meas(meas));
    vsl_line_state #(.TICK_LEN(TL)) u_dut (.clk(clk), .sys_rst(sys_rst), .setting(st),
        .meas(meas), .line_state_inhibit(inh), .phase_voltage_present(pvp),
        .phase_current_present(pcp), .line_dead_flag(dead), .line_live_flag(live),
        .vt_fail_flag(fail));

    // clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic chk_bit(logic got, logic exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_vec(logic [2:0] got, logic [2:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: starts %b, wanted %b", $time, got, exp);
        end
    endtask : chk_vec

    // wait n edges, then sample at the falling edge
    task automatic hold(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : hold

    task automatic ms(int n);
        hold(n * TL);
    endtask : ms

    task automatic drive(logic [2:0][15:0] v_i, logic [2:0][15:0] c_i, logic [3:0][15:0] s_i);
        @(posedge clk);
        volt <= v_i;
        curr <= c_i;
        seq  <= s_i;
    endtask : drive

    task automatic line(logic [2:0][15:0] v_i, logic [2:0][15:0] c_i, logic d, logic l);
        drive(v_i, c_i, '0);
        hold(8);
        chk_bit(dead, d);
        chk_bit(live, l);
    endtask : line

    // main sequence
    initial
    begin
        failures = 0;
        tests_run = 0;
        cyc = 0;
        inh = 1'b0;
        st = {DEF_ENABLE, DEF_VOLT_PCT, DEF_CURR_PCT, MODE_RESIDUAL, 7'h14, 7'h0a, 7'h14, 7'h0a};
        volt = {VL, VL, VL};
        curr = {L, L, L};
        seq = '0;
        fv[0] = {H, L, Z, Z};
        bv[0] = {H, H, Z, Z};
        fv[1] = {Z, Z, H, L};
        bv[1] = {Z, Z, H, H};
        fv[2] = {H, L, Z, L};
        bv[2] = {H, L, Z, H};
        sys_rst = 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        line({VL, VL, VL}, {L, L, L}, 1'b0, 1'b0);
        @(posedge clk);
        st.enable <= 1'b1;
        drive({VH, 16'h17d4, 16'h170c}, {L, 16'h044c, 16'h0384}, '0);
        hold(8);
        chk_vec(pvp, 3'h6);
        chk_vec(pcp, 3'h2);
        // one phase at a time
        for (int k = 0; k < 3; k++)
        begin
            v = {VL, VL, VL};
            v[k] = VH;
            c = {L, L, L};
            c[k] = H;
            drive(v, c, '0);
            hold(8);
            chk_vec(pvp, 3'(1 << k));
            chk_vec(pcp, 3'(1 << k));
        end
        line({VL, VL, VL}, {L, L, L}, 1'b1, 1'b0);
        line({VL, VL, VL}, {L, L, H}, 1'b0, 1'b0);
        line({VH, VH, VL}, {L, L, L}, 1'b0, 1'b0);
        line({VH, VH, VH}, {H, H, H}, 1'b0, 1'b1);
        line({16'h16a8, 16'h16a8, 16'h16a8}, {L, L, L}, 1'b0, 1'b1);
        line({16'h15e0, 16'h15e0, 16'h15e0}, {L, L, L}, 1'b1, 1'b0);
        line({VH, VH, VH}, {L, L, L}, 1'b0, 1'b1);
        @(posedge clk);
        inh <= 1'b1;
        hold(4);
        chk_bit(live, 1'b0);
        chk_vec(pvp, 3'h0);
        @(posedge clk);
        inh <= 1'b0;
        // lowest thresholds: 10 % voltage, 2 % current
        @(posedge clk);
        st.volt_pct <= VOLT_PCT_MIN;
        st.curr_pct <= CURR_PCT_MIN;
        drive({16'h04b0, 16'h0384, VH}, {16'h00fa, 16'h0096, L}, '0);
        hold(8);
        chk_vec(pvp, 3'h5);
        chk_vec(pcp, 3'h4);
        @(posedge clk);
        st.volt_pct <= DEF_VOLT_PCT;
        st.curr_pct <= DEF_CURR_PCT;
        // supervision in each mode
        for (int m = 0; m < 3; m++)
        begin
            @(posedge clk);
            st.mode <= vsl_mode_type'(m);
            line({VL, VL, VL}, {L, L, L}, 1'b1, 1'b0);
            drive({VH, VH, VH}, {L, L, L}, fv[m]);
            ms(195);
            chk_bit(fail, 1'b0);
            ms(20);
            chk_bit(fail, 1'b1);
            line({VH, VH, VH}, {L, L, L}, 1'b0, 1'b1);
            ms(190);
            chk_bit(fail, 1'b1);
            ms(25);
            chk_bit(fail, 1'b0);
            drive({VH, VH, VH}, {L, L, L}, fv[m]);
            ms(3);
            drive({VH, VH, VH}, {L, L, L}, bv[m]);
            ms(10);
            chk_bit(fail, 1'b0);
            drive({VH, VH, VH}, {L, L, L}, fv[m]);
            ms(7);
            chk_bit(fail, 1'b1);
            line({VL, VL, VL}, {L, L, L}, 1'b1, 1'b0);
            chk_bit(fail, 1'b0);
        end
        // old failure survives dead line and reclosing
        drive({VH, VH, VH}, {L, L, L}, fv[2]);
        ms(365);
        line({VL, VL, VL}, {L, L, L}, 1'b1, 1'b0);
        ms(50);
        chk_bit(fail, 1'b1);
        line({VH, VH, VH}, {L, L, L}, 1'b0, 1'b1);
        chk_bit(fail, 1'b1);
        ms(220);
        chk_bit(fail, 1'b0);
        // unused mode code never reports a failure while armed
        @(posedge clk);
        st.mode <= vsl_mode_type'(2'b11);
        drive({VH, VH, VH}, {L, L, L}, fv[2]);
        ms(10);
        chk_bit(fail, 1'b0);
        @(posedge clk);
        inh <= 1'b1;
        st.mode <= MODE_SPECIAL;
        drive({VH, VH, VH}, {L, L, L}, fv[2]);
        ms(10);
        chk_bit(fail, 1'b0);
        close_out();
    end
endmodule : vsl_line_state_test
